// *** core/tmpc_params.svh ***
// Constants for the transceiver mode pin control block.
// What this block does
// - While the reset pin is low the block stays in Off and clears its packet memory and settings.
// - After the reset pin rises the block enters Idle with all settings at their defaults.
// - In Idle, a rising edge on radio_sequence_enable starts a receive or transmit sequence chosen by the programmed mode.
// - Dropping radio_sequence_enable during a receive or transmit sequence returns the block to Idle and abandons the sequence.
// - A low level on wake_request_n moves the block from Hibernate or Doze to Idle.
// - With the alternate-function bit set, crc_valid_pin shows CRC-valid status instead of plain I/O.
// - With the alternate-function bit set, out_of_idle_pin shows that the block has left Idle.
`ifndef TMPC_PARAMS_SVH
`define TMPC_PARAMS_SVH
`define TMPC_GPIO_ALT_REG   8'h09
`define TMPC_GPIO_ALT_BIT   7
`define TMPC_MODE_RX        1'b0
`define TMPC_RAM_DEPTH      64
`define TMPC_RAM_WIDTH      16
`define TMPC_SYNC_STAGES    3
`endif

// *** core/tmpc_pkg.sv ***
// Types shared by the transceiver mode pin control block.
package tmpc_pkg;
  typedef enum logic [5:0] {
    TMPC_OFF   = 6'h01,
    TMPC_IDLE  = 6'h02,
    TMPC_HIB   = 6'h04,
    TMPC_DOZE  = 6'h08,
    TMPC_RX    = 6'h10,
    TMPC_TX    = 6'h20
  } tmpc_state_t;

  typedef struct packed {
    logic out;
    logic oe;
  } tmpc_pin_drive_t;

  typedef struct packed {
    logic gpio_alt_en;
    logic mode_tx;
    logic hib_req;
    logic doze_req;
  } tmpc_cfg_t;
endpackage

// *** core/tmpc_ram.sv ***
// Small packet memory with a registered read port; the clear sweep is driven from tmpc_top.
`timescale 1ns/100ps
`include "tmpc_params.svh"
module tmpc_ram #(
  parameter int WIDTH = `TMPC_RAM_WIDTH,
  parameter int DEPTH = `TMPC_RAM_DEPTH
) (
  input  wire logic                     clk_in,
  input  wire logic                     ce_in,
  input  wire logic                     we_in,
  input  wire logic [$clog2(DEPTH)-1:0] addr_in,
  input  wire logic [WIDTH-1:0]         wdata_in,
  output logic      [WIDTH-1:0]         rdata_out
);
  logic [WIDTH-1:0] mem [DEPTH];

  if (DEPTH < 2 || WIDTH < 1) begin : g_bad
    $error("tmpc_ram: bad geometry");
  end

  always_ff @(posedge clk_in) begin
    if (ce_in) begin
      if (we_in) begin
        mem[addr_in] <= wdata_in;
      end
      rdata_out <= mem[addr_in];
    end
  end
endmodule

// *** core/tmpc_top.sv ***
// Mode sequencer for the transceiver control pins and status GPIOs.
`timescale 1ns/100ps
`include "tmpc_params.svh"
module tmpc_top
  import tmpc_pkg::*;
#(
  parameter int RAM_DEPTH = `TMPC_RAM_DEPTH,
  parameter int RAM_WIDTH = `TMPC_RAM_WIDTH
) (
  input  wire logic                 clk_in,
  input  wire logic                 rst_in,
  input  wire logic                 ce_in,
  input  wire logic                 chip_reset_n_in,
  input  wire logic                 radio_sequence_enable_in,
  input  wire logic                 wake_request_n_in,
  input  wire tmpc_cfg_t            cfg_in,
  input  wire logic                 cfg_we_in,
  input  wire logic                 seq_done_in,
  input  wire logic                 crc_valid_in,
  input  wire tmpc_pin_drive_t      out_of_idle_pin_drive_in,
  input  wire tmpc_pin_drive_t      crc_valid_pin_drive_in,
  input  wire logic                 ram_we_in,
  input  wire logic [$clog2(RAM_DEPTH)-1:0] ram_addr_in,
  input  wire logic [RAM_WIDTH-1:0] ram_wdata_in,
  output logic      [RAM_WIDTH-1:0] ram_rdata_out,
  output logic                      ram_clear_busy_out,
  output tmpc_state_t               state_out,
  output tmpc_cfg_t                 cfg_out,
  output logic                      out_of_idle_pin_out,
  output logic                      out_of_idle_pin_oe_out,
  output logic                      crc_valid_pin_out,
  output logic                      crc_valid_pin_oe_out
);
  localparam int AW = $clog2(RAM_DEPTH);

  // Elaboration checks: the sweep wraps on a power-of-two depth, and edges
  // are taken from the last two stages of each synchroniser.
  if (RAM_DEPTH < 2 || (RAM_DEPTH & (RAM_DEPTH - 1)) != 0) begin : g_bad
    $error("tmpc_top: RAM_DEPTH must be a power of two");
  end
  if (`TMPC_SYNC_STAGES < 3) begin : g_bad_sync
    $error("tmpc_top: synchronisers need three stages");
  end

  // Host pins as one vector: bit 0 chip reset, bit 1 enable, bit 2 wake.
  // Each chain resets to its pin's idle level, so that leaving reset never
  // shows a false edge on any of the three pins.
  localparam int              NPIN     = 3;
  localparam int              SN       = `TMPC_SYNC_STAGES;
  localparam logic [NPIN-1:0] PIN_IDLE = 3'h4;

  wire [NPIN-1:0] pin_raw = {wake_request_n_in, radio_sequence_enable_in,
                             chip_reset_n_in};
  wire [NPIN-1:0] pin_lvl;
  wire [NPIN-1:0] pin_agree;
  wire [NPIN-1:0] pin_last;

  for (genvar gi = 0; gi < NPIN; gi++) begin : g_sync
    logic [SN-1:0] sync_reg;
    logic          lvl_reg;

    // Only stage two reads stage one, so a metastable first stage never
    // reaches the decoding logic.
    always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
        sync_reg <= {SN{PIN_IDLE[gi]}};
      end else if (ce_in) begin
        sync_reg <= {sync_reg[SN-2:0], pin_raw[gi]};
      end
    end

    // A level only changes once the last two stages agree.
    always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
        lvl_reg <= PIN_IDLE[gi];
      end else if (ce_in && pin_agree[gi]) begin
        lvl_reg <= pin_last[gi];
      end
    end

    assign pin_agree[gi] = sync_reg[SN-1] == sync_reg[SN-2];
    assign pin_last[gi]  = sync_reg[SN-1];
    assign pin_lvl[gi]   = lvl_reg;
  end

  wire chip_in_reset = !pin_lvl[0];
  wire seq_lvl       = pin_lvl[1];
  // The edge is taken from the agreeing stages one cycle before the level
  // moves, so each host transition starts at most one sequence.
  wire seq_rise      = pin_agree[1] && pin_last[1] && !seq_lvl;
  wire wake_active   = !pin_lvl[2];

  // Memory clear sweep runs after reset so stale packets never survive.
  logic [AW-1:0] clr_addr_reg;
  logic          clr_busy_reg;
  logic          clr_busy_next;

  assign clr_busy_next = chip_in_reset ? 1'b1 :
                         (clr_addr_reg == AW'(RAM_DEPTH - 1)) ? 1'b0 :
                         clr_busy_reg;

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      clr_addr_reg <= '0;
      clr_busy_reg <= 1'b1;
    end else if (ce_in) begin
      clr_busy_reg <= clr_busy_next;
      clr_addr_reg <= clr_busy_reg ? clr_addr_reg + AW'(1) : '0;
    end
  end

  wire                 ram_we    = clr_busy_reg | (ram_we_in & ~chip_in_reset);
  wire [AW-1:0]        ram_addr  = clr_busy_reg ? clr_addr_reg : ram_addr_in;
  wire [RAM_WIDTH-1:0] ram_wdata = clr_busy_reg ? '0 : ram_wdata_in;

  tmpc_ram #(
    .WIDTH (RAM_WIDTH),
    .DEPTH (RAM_DEPTH)
  ) u_ram (
    .clk_in    (clk_in),
    .ce_in     (ce_in),
    .we_in     (ram_we),
    .addr_in   (ram_addr),
    .wdata_in  (ram_wdata),
    .rdata_out (ram_rdata_out)
  );

  // Settings register, written below once the wake decode exists.
  tmpc_cfg_t cfg_reg;

  // Mode sequencer.
  tmpc_state_t state_reg;
  tmpc_state_t state_next;

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      TMPC_OFF: begin
        if (!chip_in_reset) state_next = TMPC_IDLE;
      end
      TMPC_IDLE: begin
        if (seq_rise) begin
          state_next = (cfg_reg.mode_tx == `TMPC_MODE_RX) ?
                       TMPC_RX : TMPC_TX;
        end else if (cfg_reg.hib_req) begin
          state_next = TMPC_HIB;
        end else if (cfg_reg.doze_req) begin
          state_next = TMPC_DOZE;
        end
      end
      TMPC_HIB, TMPC_DOZE: begin
        if (wake_active) state_next = TMPC_IDLE;
      end
      TMPC_RX, TMPC_TX: begin
        // Either seq_done_in or the host dropping the enable ends the run.
        if (!seq_lvl || seq_done_in) state_next = TMPC_IDLE;
      end
      default: state_next = TMPC_OFF;
    endcase
    if (chip_in_reset) state_next = TMPC_OFF;
  end

  // Sleep requests are one-shot so waking does not re-enter sleep at once.
  wire clear_sleep = (state_reg == TMPC_HIB || state_reg == TMPC_DOZE) &&
                     wake_active;

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      state_reg <= TMPC_OFF;
    end else if (ce_in) begin
      state_reg <= state_next;
    end
  end

  // The sleep bits are cleared in the settings themselves when a wake
  // fires; otherwise Idle would fall straight back into sleep.
  tmpc_cfg_t cfg_woken;
  tmpc_cfg_t cfg_view;
  assign cfg_woken = '{cfg_reg.gpio_alt_en, cfg_reg.mode_tx, 1'b0, 1'b0};
  assign cfg_view  = clear_sleep ? cfg_woken : cfg_reg;

  // Held at defaults while the chip reset is low; a host write in the
  // cycle of a wake wins over the sleep clear.
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      cfg_reg <= '0;
    end else if (ce_in) begin
      if (chip_in_reset) begin
        cfg_reg <= '0;
      end else if (cfg_we_in) begin
        cfg_reg <= cfg_in;
      end else if (clear_sleep) begin
        cfg_reg <= cfg_woken;
      end
    end
  end

  // Status pins; alternate function overrides the ordinary GPIO drive.
  wire alt_en = cfg_reg.gpio_alt_en;
  wire gp1_o  = alt_en ? (state_next != TMPC_IDLE) : out_of_idle_pin_drive_in.out;
  wire gp1_oe = alt_en ? 1'b1 : out_of_idle_pin_drive_in.oe;
  wire gp2_o  = alt_en ? crc_valid_in : crc_valid_pin_drive_in.out;
  wire gp2_oe = alt_en ? 1'b1 : crc_valid_pin_drive_in.oe;

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      state_out              <= TMPC_OFF;
      cfg_out                <= '0;
      ram_clear_busy_out     <= 1'b1;
      out_of_idle_pin_out    <= 1'b0;
      out_of_idle_pin_oe_out <= 1'b0;
      crc_valid_pin_out      <= 1'b0;
      crc_valid_pin_oe_out   <= 1'b0;
    end else if (ce_in) begin
      state_out              <= state_next;
      cfg_out                <= cfg_view;
      ram_clear_busy_out     <= clr_busy_next;
      out_of_idle_pin_out    <= gp1_o;
      out_of_idle_pin_oe_out <= gp1_oe;
      crc_valid_pin_out      <= gp2_o;
      crc_valid_pin_oe_out   <= gp2_oe;
    end
  end

endmodule

// *** tb/tmpc_host_model.sv ***
// Host model that drives the control pins and the settings port.
`timescale 1ns/100ps
module tmpc_host_model
  import tmpc_pkg::*;
(
  input  wire logic clk_in,
  output logic      rst_n_out,
  output logic      seq_en_out,
  output logic      wake_n_out,
  output tmpc_cfg_t cfg_out,
  output logic      cfg_we_out
);
  initial begin
    rst_n_out = 1'h0;
    seq_en_out = 1'h0;
    wake_n_out = 1'h1;
    cfg_out = '0;
    cfg_we_out = 1'h0;
  end
  // Settings are written whole before any enable edge.
  task automatic write_cfg(input tmpc_cfg_t c);
    @(posedge clk_in) #1;
    cfg_out = c;
    cfg_we_out = 1'h1;
    @(posedge clk_in) #1;
    cfg_we_out = 1'h0;
  endtask
  // The enable is a held level, dropped only by the caller.
  task automatic set_en(input logic v);
    @(posedge clk_in) #1;
    seq_en_out = v;
  endtask
  task automatic set_pins(input logic r, input logic w);
    @(posedge clk_in) #1;
    rst_n_out = r;
    wake_n_out = w;
  endtask
endmodule

// *** tb/tmpc_top_sva.sv ***
// Port checks for the mode pin control block.
`timescale 1ns/100ps
module tmpc_top_sva
  import tmpc_pkg::*;
(
  input wire logic            clk_in,
  input wire logic            rst_in,
  input wire logic            ce_in,
  input wire logic            chip_reset_n_in,
  input wire logic            radio_sequence_enable_in,
  input wire logic            wake_request_n_in,
  input wire logic            crc_valid_in,
  input wire tmpc_pin_drive_t out_of_idle_pin_drive_in,
  input wire tmpc_pin_drive_t crc_valid_pin_drive_in,
  input wire tmpc_state_t     state_out,
  input wire tmpc_cfg_t       cfg_out,
  input wire logic            out_of_idle_pin_out,
  input wire logic            out_of_idle_pin_oe_out,
  input wire logic            crc_valid_pin_out,
  input wire logic            crc_valid_pin_oe_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in || !ce_in);
  a_off_in_reset: assert property (
    !chip_reset_n_in [*6] |-> state_out == TMPC_OFF)
    else $error("not off under chip reset");
  a_idle_after_reset: assert property (
    $rose(chip_reset_n_in) && !radio_sequence_enable_in
    |-> ##[2:8] state_out == TMPC_IDLE) else $error("no idle after reset");
  a_seq_start: assert property (
    $rose(radio_sequence_enable_in) && state_out == TMPC_IDLE
    |-> ##[2:8] state_out == (cfg_out.mode_tx ? TMPC_TX : TMPC_RX))
    else $error("sequence not started");
  a_enable_low_idle: assert property (
    $fell(radio_sequence_enable_in) && state_out inside {TMPC_RX, TMPC_TX}
    |-> ##[2:8] state_out == TMPC_IDLE) else $error("no abort to idle");
  a_wake_to_idle: assert property (
    $fell(wake_request_n_in) && state_out inside {TMPC_HIB, TMPC_DOZE}
    |-> ##[2:8] state_out == TMPC_IDLE) else $error("wake ignored");
  a_alt_idle_pin: assert property (
    (cfg_out.gpio_alt_en && $stable(state_out)) [*2] |->
    out_of_idle_pin_oe_out && out_of_idle_pin_out == (state_out != TMPC_IDLE))
    else $error("out of idle pin wrong");
  a_alt_crc_pin: assert property (
    (cfg_out.gpio_alt_en && $stable(crc_valid_in)) [*3] |->
    crc_valid_pin_oe_out && crc_valid_pin_out == crc_valid_in)
    else $error("crc pin wrong");
  a_plain_gpio: assert property (
    (!cfg_out.gpio_alt_en && $stable(out_of_idle_pin_drive_in)) [*3] |->
    {out_of_idle_pin_out, out_of_idle_pin_oe_out} == out_of_idle_pin_drive_in)
    else $error("plain gpio wrong");
  a_plain_crc_gpio: assert property (
    (!cfg_out.gpio_alt_en && $stable(crc_valid_pin_drive_in)) [*3] |->
    {crc_valid_pin_out, crc_valid_pin_oe_out} == crc_valid_pin_drive_in)
    else $error("plain crc gpio wrong");
endmodule
bind tmpc_top tmpc_top_sva u_sva (.clk_in, .rst_in, .ce_in, .chip_reset_n_in,
  .radio_sequence_enable_in, .wake_request_n_in, .crc_valid_in,
  .out_of_idle_pin_drive_in, .crc_valid_pin_drive_in, .state_out, .cfg_out, .out_of_idle_pin_out,
  .out_of_idle_pin_oe_out, .crc_valid_pin_out, .crc_valid_pin_oe_out);

// *** tb/testbench.sv ***
// Testbench for the mode pin control block.
`timescale 1ns/100ps
module testbench;
  import tmpc_pkg::*;
  logic            clk_in = 1'h0, rst_in = 1'h1, done = 1'h0, crc = 1'h0;
  logic            rn, en, wn, we, p1, p1oe, p2, p2oe, busy;
  logic            ce = 1'h1, rwe = 1'h0;
  logic [5:0]      ra = '0;
  logic [15:0]     rwd = '0, rd;
  tmpc_pin_drive_t g1 = '0, g2 = '0;
  tmpc_cfg_t       hc, cfg;
  tmpc_state_t     st;
  int              n_fail = 0, checked = 0;
  tmpc_host_model h (.clk_in, .rst_n_out(rn), .seq_en_out(en),
    .wake_n_out(wn), .cfg_out(hc), .cfg_we_out(we));
  tmpc_top DUT (.clk_in, .rst_in, .ce_in(ce), .chip_reset_n_in(rn),
    .radio_sequence_enable_in(en), .wake_request_n_in(wn), .cfg_in(hc),
    .cfg_we_in(we), .seq_done_in(done), .crc_valid_in(crc),
    .out_of_idle_pin_drive_in(g1), .crc_valid_pin_drive_in(g2), .ram_we_in(rwe),
    .ram_addr_in(ra), .ram_wdata_in(rwd), .ram_rdata_out(rd),
    .ram_clear_busy_out(busy), .state_out(st), .cfg_out(cfg),
    .out_of_idle_pin_out(p1), .out_of_idle_pin_oe_out(p1oe),
    .crc_valid_pin_out(p2), .crc_valid_pin_oe_out(p2oe));
  initial begin
    forever #5 clk_in = ~clk_in;
  end
  task automatic end_sim;
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic chk(input logic ok, input string m);
    checked++;
    if (ok !== 1'h1) begin
      n_fail++;
      $display("wrong value at %0t: %s", $time, m);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask
  // Bounded wait; a miss ends the run.
  task automatic wait_st(input tmpc_state_t e);
    for (int i = 0; i < 20 && st !== e; i++) tick(1);
    chk(st === e, "state");
    if (st !== e) end_sim();
  endtask
  task automatic t_reset;
    h.set_pins(1'h0, 1'h1);
    tick(6);
    chk(st === TMPC_OFF && cfg === '0 && busy === 1'h1, "off");
    h.set_pins(1'h1, 1'h1);
    wait_st(TMPC_IDLE);
    for (int i = 0; i < 90 && busy !== 1'h0; i++) tick(1);
    chk(busy === 1'h0 && cfg === '0, "sweep");
    if (busy !== 1'h0) end_sim();
  endtask
  task automatic t_seq(input logic m);
    h.write_cfg('{1'h1, m, 1'h0, 1'h0});
    h.set_en(1'h1);
    wait_st(m ? TMPC_TX : TMPC_RX);
    tick(1);
    chk(p1 === 1'h1 && p1oe === 1'h1, "idle pin");
    done = 1'h1;
    tick(1);
    done = 1'h0;
    wait_st(TMPC_IDLE);
    tick(8);
    chk(st === TMPC_IDLE && p1 === 1'h0, "restart");
    h.set_en(1'h0);
    tick(6);
  endtask
  task automatic t_abort;
    h.write_cfg('0);
    h.set_en(1'h1);
    wait_st(TMPC_RX);
    h.set_en(1'h0);
    wait_st(TMPC_IDLE);
  endtask
  task automatic t_wake(input logic hb);
    h.write_cfg('{1'h0, 1'h0, hb, ~hb});
    wait_st(hb ? TMPC_HIB : TMPC_DOZE);
    h.set_pins(1'h1, 1'h0);
    wait_st(TMPC_IDLE);
    h.set_pins(1'h1, 1'h1);
    tick(6);
  endtask
  task automatic t_gpio;
    g1 = '{1'h1, 1'h1};
    g2 = '{1'h0, 1'h1};
    tick(4);
    chk({p1, p1oe, p2, p2oe} === 4'hD, "gpio");
    crc = 1'h1;
    h.write_cfg('{1'h1, 1'h0, 1'h0, 1'h0});
    tick(4);
    chk(p2 === 1'h1 && p2oe === 1'h1, "crc pin");
    chk(p1 === 1'h0 && p1oe === 1'h1, "idle pin low");
    crc = 1'h0;
    tick(4);
    chk(p2 === 1'h0, "crc low");
  endtask
  // Optional write, then read back one word; a sweep must leave zero.
  task automatic t_ram(input logic wr, input logic [15:0] d);
    ra = 6'h05;
    rwd = 16'hA5C3;
    rwe = wr;
    tick(1);
    rwe = 1'h0;
    tick(1);
    chk(rd === d, "ram");
  endtask
  // With the clock enable low nothing moves, then the held edge acts once.
  task automatic t_ce;
    ce = 1'h0;
    h.set_en(1'h1);
    tick(8);
    chk(st === TMPC_IDLE, "frozen");
    ce = 1'h1;
    wait_st(TMPC_RX);
    h.set_en(1'h0);
    wait_st(TMPC_IDLE);
  endtask
  initial begin
    tick(2);
    rst_in = 1'h0;
    t_reset();
    t_ram(1'h1, 16'hA5C3);
    t_seq(1'h0);
    t_seq(1'h1);
    t_abort();
    t_ce();
    t_wake(1'h1);
    t_wake(1'h0);
    t_gpio();
    t_reset();
    t_ram(1'h0, 16'h0000);
    end_sim();
  end
endmodule
